// [verilog/power_stage_config_irq.sv]
// Register file, update lock, pin routing and interrupts of the power stage.
//
// Contract
// - A match of the counter with the B-reset value raises the end vector.
// - A fault event on any module input raises the separate fault vector.
// - Six enable bits route 0A,0B,1A,1B,2A,2B waveforms to their pins.
// - The sync register holds a two-bit selector per module at 1:0,3:2,5:4.
// - In one-ramp mode codes pick A or B leading or trailing edge events.
// - In centre mode codes 0 and 1 pick A-reset match down or up, 2,3 none.
// - Four 12-bit compare values are compared with the counter all along.
// - Compare writes pass through one shared 8-bit high-byte holder.
// - While locked, compare and pin enable writes wait until unlock.
// - The ramp mode bit picks one-ramp at 0 and centre-aligned at 1.
// - The B polarity bit makes B outputs active high when set.
// - The A polarity bit makes A outputs active high when set.
// - Compare registers are replicated for modules 0, 1 and 2.
// - Fault flags are set by events, cleared by writing one, always read.
// - The end-of-cycle enable bit gates the end of cycle request.
`timescale 1ns/1ps
`include "pwr_stage_regs.svh"
module power_stage_config_irq (
  // Clock and reset
  input  wire logic                        I_CORE_CLK,
  input  wire logic                        I_ARST_N,
  // AHB-Lite slave
  input  wire logic                        I_HSEL,
  input  wire logic [31:0]                 I_HADDR,
  input  wire logic [1:0]                  I_HTRANS,
  input  wire logic                        I_HWRITE,
  input  wire logic [2:0]                  I_HSIZE,
  input  wire logic [31:0]                 I_HWDATA,
  input  wire logic                        I_HREADY,
  output logic                             O_HREADYOUT,
  output logic [31:0]                      O_HRDATA,
  output logic                             O_HRESP,
  // Counter engine state, one entry per module
  input  wire pwr_stage_pkg::engine_t [2:0] I_ENGINE,
  input  wire logic [2:0]                  I_FAULT_EVT,
  // Pins and ADC trigger
  output logic [5:0]                       O_PIN_OE,
  output logic [5:0]                       O_PIN_OUT,
  output logic [2:0]                       O_ADC_SYNC,
  // Interrupts
  output logic                             O_IRQ,
  output logic                             O_IRQ_END,
  output logic                             O_IRQ_FAULT
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  function automatic logic [11:0] cmp_get(
    input pwr_stage_pkg::cmp_t c,
    input logic [1:0]          f
  );
    logic [11:0] v;
    v = c.a_set;
    unique case (f)
      2'h0: v = c.a_set;
      2'h1: v = c.a_reset;
      2'h2: v = c.b_set;
      2'h3: v = c.b_reset;
    endcase
    return v;
  endfunction

  function automatic pwr_stage_pkg::cmp_t cmp_put(
    input pwr_stage_pkg::cmp_t c,
    input logic [1:0]          f,
    input logic [11:0]         v
  );
    pwr_stage_pkg::cmp_t r;
    r = c;
    unique case (f)
      2'h0: r.a_set   = v;
      2'h1: r.a_reset = v;
      2'h2: r.b_set   = v;
      2'h3: r.b_reset = v;
    endcase
    return r;
  endfunction

  // Compare registers occupy the address blocks of modules 0 to 2.
  function automatic logic is_cmp(input logic [7:0] a);
    return (a[7:5] >= `PWR_CMP_MOD_FIRST) && (a[7:5] <= `PWR_CMP_MOD_LAST);
  endfunction

  function automatic logic [1:0] cmp_mod(input logic [7:0] a);
    return 2'(a[7:5] - `PWR_CMP_MOD_FIRST);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  pwr_stage_pkg::bus_state_t bus_state;
  logic                      dp_write;
  logic [7:0]                dp_addr;
  logic                      dp_mapped;
  logic                      ap_valid;
  logic                      ap_mapped;
  logic                      wr_en;
  logic [7:0]                wr_byte;
  logic [31:0]               rd_value;

  logic [5:0]                pin_en_prog;
  logic [5:0]                pin_en_act;
  logic [5:0]                sync_sel;
  pwr_stage_pkg::gen_cfg_t   cfg;
  pwr_stage_pkg::cmp_t       cmp_prog [3];
  pwr_stage_pkg::cmp_t       cmp_act [3];
  logic [7:0]                hold;
  logic [3:0]                status;
  logic [3:0]                mask;
  logic [3:0]                next_status;
  logic [3:0]                clr;
  logic [2:0]                end_match;
  logic [2:0]                wave_a;
  logic [2:0]                wave_b;
  logic [2:0]                sync_pulse;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------

  // A transfer is taken only when selected, ready and not idle or busy.
  always_comb begin
    ap_valid  = I_HSEL && I_HREADY && I_HTRANS[1];
    ap_mapped = (I_HADDR[31:8] == `PWR_HIGH_ZERO) &&
                (I_HADDR[1:0] == `PWR_LANE_ZERO);
    wr_en     = dp_write && dp_mapped;
    wr_byte   = I_HWDATA[7:0];
  end

  // Writes never stall; reads take one wait state so that a write in the
  // preceding data phase is already visible.
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      bus_state   <= pwr_stage_pkg::BUS_IDLE;
      dp_write    <= 1'b0;
      dp_addr     <= `PWR_RST_BYTE;
      dp_mapped   <= 1'b0;
      O_HREADYOUT <= 1'b1;
      O_HRDATA    <= `PWR_RST_WORD;
      O_HRESP     <= 1'b0;
    end else begin
      O_HRESP <= 1'b0;
      unique case (bus_state)
        pwr_stage_pkg::BUS_IDLE: begin
          dp_write <= ap_valid && I_HWRITE;
          if (ap_valid) begin
            dp_addr   <= I_HADDR[7:0];
            dp_mapped <= ap_mapped;
          end
          if (ap_valid && !I_HWRITE) begin
            bus_state   <= pwr_stage_pkg::BUS_READ;
            O_HREADYOUT <= 1'b0;
          end
        end
        pwr_stage_pkg::BUS_READ: begin
          dp_write    <= 1'b0;
          O_HRDATA    <= dp_mapped ? rd_value : `PWR_RST_WORD;
          O_HREADYOUT <= 1'b1;
          bus_state   <= pwr_stage_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Read data is formed from the address held since the address phase.
  always_comb begin
    logic [11:0] v;
    v        = cmp_get(cmp_prog[0], 2'h0);
    rd_value = `PWR_RST_WORD;
    unique case (dp_addr)
      `PWR_ADDR_PIN_EN: rd_value = {26'h0, pin_en_prog};
      `PWR_ADDR_SYNC:   rd_value = {26'h0, sync_sel};
      `PWR_ADDR_CONFIG: rd_value = {26'h0, cfg, 2'h0};
      `PWR_ADDR_STATUS: rd_value = {28'h0, status};
      `PWR_ADDR_MASK:   rd_value = {28'h0, mask};
      default: begin
        if (is_cmp(dp_addr)) begin
          v = cmp_get(cmp_prog[cmp_mod(dp_addr)], dp_addr[4:3]);
          rd_value = dp_addr[2] ? {28'h0, v[11:8]} : {24'h0, v[7:0]};
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pin_en_prog <= `PWR_RST_PINS;
      sync_sel    <= `PWR_RST_PINS;
      cfg         <= `PWR_RST_FLAGS;
      mask        <= `PWR_RST_FLAGS;
    end else if (wr_en) begin
      if (dp_addr == `PWR_ADDR_PIN_EN) begin
        pin_en_prog <= wr_byte[5:0];
      end
      if (dp_addr == `PWR_ADDR_SYNC) begin
        sync_sel <= wr_byte[5:0];
      end
      if (dp_addr == `PWR_ADDR_CONFIG) begin
        cfg.lock  <= wr_byte[`PWR_CFG_LOCK];
        cfg.mode  <= wr_byte[`PWR_CFG_MODE];
        cfg.pol_b <= wr_byte[`PWR_CFG_POL_B];
        cfg.pol_a <= wr_byte[`PWR_CFG_POL_A];
      end
      if (dp_addr == `PWR_ADDR_MASK) begin
        mask <= wr_byte[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Compare registers and shared high byte
  // ---------------------------------------------------------------

  // The high byte waits here until the low byte of a compare arrives.
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hold <= `PWR_RST_BYTE;
    end else if (wr_en && is_cmp(dp_addr) && dp_addr[2]) begin
      hold <= wr_byte;
    end
  end

  // The low byte write commits the held high byte in the same edge.
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int m = 0; m < 3; m++) begin
        cmp_prog[m] <= '0;
      end
    end else if (wr_en && is_cmp(dp_addr) && !dp_addr[2]) begin
      cmp_prog[cmp_mod(dp_addr)] <= cmp_put(cmp_prog[cmp_mod(dp_addr)],
        dp_addr[4:3], {hold[3:0], wr_byte});
    end
  end

  // Shadow copies seen by the generator follow only while unlocked.
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int m = 0; m < 3; m++) begin
        cmp_act[m] <= '0;
      end
      pin_en_act <= `PWR_RST_PINS;
    end else if (!cfg.lock) begin
      for (int m = 0; m < 3; m++) begin
        cmp_act[m] <= cmp_prog[m];
      end
      pin_en_act <= pin_en_prog;
    end
  end

  // ---------------------------------------------------------------
  // Generator modules
  // ---------------------------------------------------------------

  for (genvar g = 0; g < 3; g++) begin : gen_mod
    power_stage_channel u_channel (
      .clk        (I_CORE_CLK),
      .rst_n      (I_ARST_N),
      .i_eng      (I_ENGINE[g]),
      .i_cmp      (cmp_act[g]),
      .i_mode     (cfg.mode),
      .i_pol_a    (cfg.pol_a),
      .i_pol_b    (cfg.pol_b),
      .i_sync_sel (sync_sel[2*g +: 2]),
      .o_wave_a   (wave_a[g]),
      .o_wave_b   (wave_b[g]),
      .o_sync     (sync_pulse[g]),
      .o_end      (end_match[g])
    );
  end

  // ---------------------------------------------------------------
  // Pin routing
  // ---------------------------------------------------------------

  // Pin enables follow the shadow copy, so the lock also holds the pins.
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PIN_OE <= `PWR_RST_PINS;
    end else begin
      O_PIN_OE <= pin_en_act;
    end
  end

  // Waveform and sync outputs are the flip-flops of the channels.
  assign O_PIN_OUT  = {wave_b[2], wave_a[2], wave_b[1], wave_a[1],
                       wave_b[0], wave_a[0]};
  assign O_ADC_SYNC = sync_pulse;

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------

  // A new event in the clearing cycle keeps its flag set.
  always_comb begin
    clr = `PWR_RST_FLAGS;
    if (wr_en && (dp_addr == `PWR_ADDR_STATUS)) begin
      clr = wr_byte[3:0];
    end
    next_status = status & ~clr;
    next_status[`PWR_IRQ_END] = next_status[`PWR_IRQ_END] |
                                (|end_match);
    next_status[`PWR_IRQ_FLT_MSB:`PWR_IRQ_FLT_LSB] =
      next_status[`PWR_IRQ_FLT_MSB:`PWR_IRQ_FLT_LSB] | I_FAULT_EVT;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      status <= `PWR_RST_FLAGS;
    end else begin
      status <= next_status;
    end
  end

  // Each interrupt output is a flip-flop, one edge behind its flags.
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_IRQ_END   <= 1'b0;
      O_IRQ_FAULT <= 1'b0;
      O_IRQ       <= 1'b0;
    end else begin
      O_IRQ_END   <= status[`PWR_IRQ_END] && mask[`PWR_IRQ_END];
      O_IRQ_FAULT <= |(status[`PWR_IRQ_FLT_MSB:`PWR_IRQ_FLT_LSB] &
                       mask[`PWR_IRQ_FLT_MSB:`PWR_IRQ_FLT_LSB]);
      O_IRQ       <= |(status & mask);
    end
  end

endmodule

// [verilog/pwr_stage_regs.svh]
// Register offsets, field positions and reset values of the power stage block.
`ifndef PWR_STAGE_REGS_SVH
`define PWR_STAGE_REGS_SVH
`define PWR_ADDR_PIN_EN   8'h00
`define PWR_ADDR_SYNC     8'h04
`define PWR_ADDR_CONFIG   8'h08
`define PWR_ADDR_STATUS   8'h0c
`define PWR_ADDR_MASK     8'h10
`define PWR_CMP_MOD_FIRST 3'h1
`define PWR_CMP_MOD_LAST  3'h3
`define PWR_HIGH_ZERO     24'h000000
`define PWR_LANE_ZERO     2'h0
`define PWR_CFG_LOCK      5
`define PWR_CFG_MODE      4
`define PWR_CFG_POL_B     3
`define PWR_CFG_POL_A     2
`define PWR_IRQ_END       0
`define PWR_IRQ_FLT_LSB   1
`define PWR_IRQ_FLT_MSB   3
`define PWR_RST_BYTE      8'h00
`define PWR_RST_PINS      6'h00
`define PWR_RST_FLAGS     4'h0
`define PWR_RST_WORD      32'h00000000
`endif

// [verilog/pwr_stage_pkg.sv]
// Types shared by the power stage configuration and interrupt logic.
package pwr_stage_pkg;
  typedef struct packed {
    logic [11:0] a_set;
    logic [11:0] a_reset;
    logic [11:0] b_set;
    logic [11:0] b_reset;
  } cmp_t;
  typedef struct packed {
    logic [11:0] count;
    logic        count_up;
    logic        fault_a;
    logic        fault_b;
  } engine_t;
  typedef struct packed {
    logic lock;
    logic mode;
    logic pol_b;
    logic pol_a;
  } gen_cfg_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_t;
endpackage

// [verilog/power_stage_channel.sv]
// One generator module: compare matches, waveforms A and B, ADC sync pulse.
`timescale 1ns/1ps
module power_stage_channel (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Engine state and settings
  input  wire pwr_stage_pkg::engine_t i_eng,
  input  wire pwr_stage_pkg::cmp_t    i_cmp,
  input  wire logic                 i_mode,
  input  wire logic                 i_pol_a,
  input  wire logic                 i_pol_b,
  input  wire logic [1:0]           i_sync_sel,
  // Results
  output logic                      o_wave_a,
  output logic                      o_wave_b,
  output logic                      o_sync,
  output logic                      o_end
);
  logic m_sa;
  logic m_ra;
  logic m_sb;
  logic m_rb;
  logic raw_a;
  logic raw_b;
  logic next_a;
  logic next_b;
  logic next_sync;

  always_comb begin
    m_sa = (i_eng.count == i_cmp.a_set);
    m_ra = (i_eng.count == i_cmp.a_reset);
    m_sb = (i_eng.count == i_cmp.b_set);
    m_rb = (i_eng.count == i_cmp.b_reset);
    next_a = raw_a;
    next_b = raw_b;
    if (i_mode) begin
      // Centre mode uses the A-set value on both slopes of the ramp.
      if (i_eng.fault_a || (m_sa && !i_eng.count_up)) begin
        next_a = 1'b0;
      end else if (m_sa && i_eng.count_up) begin
        next_a = 1'b1;
      end
    end else if (i_eng.fault_a || m_ra) begin
      next_a = 1'b0;
    end else if (m_sa) begin
      next_a = 1'b1;
    end
    if (i_eng.fault_b || m_rb) begin
      next_b = 1'b0;
    end else if (m_sb) begin
      next_b = 1'b1;
    end
    next_sync = 1'b0;
    if (i_mode) begin
      unique case (i_sync_sel)
        2'h0: next_sync = m_ra && !i_eng.count_up;
        2'h1: next_sync = m_ra && i_eng.count_up;
        2'h2: next_sync = 1'b0;
        2'h3: next_sync = 1'b0;
      endcase
    end else begin
      unique case (i_sync_sel)
        2'h0: next_sync = m_sa;
        2'h1: next_sync = m_ra || i_eng.fault_a;
        2'h2: next_sync = m_sb;
        2'h3: next_sync = m_rb || i_eng.fault_b;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_a    <= 1'b0;
      raw_b    <= 1'b0;
      o_wave_a <= 1'b0;
      o_wave_b <= 1'b0;
      o_sync   <= 1'b0;
      o_end    <= 1'b0;
    end else begin
      raw_a    <= next_a;
      raw_b    <= next_b;
      o_wave_a <= i_pol_a ? next_a : ~next_a;
      o_wave_b <= i_pol_b ? next_b : ~next_b;
      o_sync   <= next_sync;
      o_end    <= m_rb;
    end
  end
endmodule

// [testbench/power_stage_config_irq_asserts.sv]
// Port assertions for the power stage configuration and interrupt block.
`timescale 1ns/1ps
module power_stage_config_irq_chk (
  // Clock and reset
  input wire logic        I_CORE_CLK,
  input wire logic        I_ARST_N,
  // Bus and events
  input wire logic        I_HSEL,
  input wire logic [1:0]  I_HTRANS,
  input wire logic        I_HWRITE,
  input wire logic        I_HREADY,
  input wire logic [2:0]  I_FAULT_EVT,
  // Outputs watched
  input wire logic        O_HREADYOUT,
  input wire logic [31:0] O_HRDATA,
  input wire logic        O_HRESP,
  input wire logic [5:0]  O_PIN_OE,
  input wire logic        O_IRQ,
  input wire logic        O_IRQ_END,
  input wire logic        O_IRQ_FAULT
);
  logic take;
  logic wr_ph;
  logic rd_ph;
  assign take = I_HSEL & I_HREADY & I_HTRANS[1];
  // Marks the data phase of each accepted transfer.
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
    end else begin
      wr_ph <= take & I_HWRITE;
      rd_ph <= take & ~I_HWRITE;
    end
  end
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_ARST_N);
  property p_okay;
    O_HRESP == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_rd_wait;
    take && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait");
  property p_wr_nowait;
    take && I_HWRITE |=> O_HREADYOUT;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write wait");
  property p_rd_hold;
    $changed(O_HRDATA) |-> $past(rd_ph);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("data moved");
  property p_irq_sum;
    O_IRQ == (O_IRQ_END | O_IRQ_FAULT);
  endproperty
  a_irq_sum: assert property (p_irq_sum) else $error("irq sum");
  property p_flt_rise;
    $rose(O_IRQ_FAULT) |-> $past(I_FAULT_EVT, 2) != 3'b000 || $past(wr_ph, 2);
  endproperty
  a_flt_rise: assert property (p_flt_rise) else $error("fault irq");
  property p_sticky;
    $fell(O_IRQ_END) || $fell(O_IRQ_FAULT) |-> $past(wr_ph, 2);
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq dropped");
  property p_oe_move;
    $changed(O_PIN_OE) |-> $past(wr_ph, 3);
  endproperty
  a_oe_move: assert property (p_oe_move) else $error("oe moved");
  c_rd: cover property (take && !I_HWRITE);
  c_flt: cover property ($rose(O_IRQ_FAULT));
  c_oe: cover property ($changed(O_PIN_OE));
endmodule
bind power_stage_config_irq power_stage_config_irq_chk u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N), .I_HSEL(I_HSEL),
  .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY),
  .I_FAULT_EVT(I_FAULT_EVT), .O_HREADYOUT(O_HREADYOUT),
  .O_HRDATA(O_HRDATA), .O_HRESP(O_HRESP), .O_PIN_OE(O_PIN_OE),
  .O_IRQ(O_IRQ), .O_IRQ_END(O_IRQ_END), .O_IRQ_FAULT(O_IRQ_FAULT)
);

// [testbench/pwr_engine_model.sv]
// Behavioural counter engine that feeds the power stage block.
`timescale 1ns/1ps
module pwr_engine_model (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Control
  input  wire logic                    i_run,
  input  wire logic                    i_up,
  input  wire logic [11:0]             i_top,
  input  wire logic [11:0]             i_hold,
  input  wire logic [2:0]              i_fault_a,
  input  wire logic [2:0]              i_fault_b,
  // Engine state
  output pwr_stage_pkg::engine_t [2:0] o_eng
);
  logic [11:0] count;
  // Holds a given value when stopped, so slow and fast matches both occur.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 12'h000;
    end else if (!i_run) begin
      count <= i_hold;
    end else if (i_up) begin
      count <= (count == i_top) ? 12'h000 : count + 12'h001;
    end else begin
      count <= (count == 12'h000) ? i_top : count - 12'h001;
    end
  end
  always_comb begin
    for (int m = 0; m < 3; m++) begin
      o_eng[m] = {count, i_up, i_fault_a[m], i_fault_b[m]};
    end
  end
endmodule

// [testbench/power_stage_config_irq_tb.sv]
// Self-checking bench for the power stage configuration and interrupts.
`timescale 1ns/1ps
module power_stage_config_irq_tb;
  logic                         clk, arst_n, hsel, hwrite, hrdy, hresp;
  logic                         run, up, irq, irq_e, irq_f;
  logic [1:0]                   htrans;
  logic [31:0]                  haddr, hwdata, hrdata, rd;
  logic [11:0]                  hold;
  logic [2:0]                   fevt, sync, fa;
  logic [5:0]                   oe, pout;
  pwr_stage_pkg::engine_t [2:0] eng;
  int                           failures, tests_run, n;
  logic [11:0]                  seen;
  logic [11:0]                  vals [4] = '{12'h005, 12'h00a, 12'h00c, 12'h00e};

  power_stage_config_irq DUT (
    .I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'b010),
    .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HREADYOUT(hrdy),
    .O_HRDATA(hrdata), .O_HRESP(hresp), .I_ENGINE(eng), .I_FAULT_EVT(fevt),
    .O_PIN_OE(oe), .O_PIN_OUT(pout), .O_ADC_SYNC(sync), .O_IRQ(irq),
    .O_IRQ_END(irq_e), .O_IRQ_FAULT(irq_f));
  pwr_engine_model u_eng (
    .clk(clk), .rst_n(arst_n), .i_run(run), .i_up(up), .i_top(12'h01f),
    .i_hold(hold), .i_fault_a(fa), .i_fault_b(3'b000), .o_eng(eng));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_rdy;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
      @(posedge clk);
    end
  endtask
  // One single AHB-Lite transfer; read data lands in rd.
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic wcmp(input int m, f, input logic [11:0] v);
    bus(1'b1, 32'(32 + 32 * m + 8 * f + 4), {28'h0, v[11:8]});
    bus(1'b1, 32'(32 + 32 * m + 8 * f), {24'h0, v[7:0]});
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] adr [6] = '{32'h0, 32'h4, 32'h8, 32'h10, 32'h38, 32'h7c};
    foreach (adr[i]) rchk("reset value", adr[i], 32'h0);
    bus(1'b1, 32'h14, 32'hff);
    rchk("unmapped", 32'h14, 32'h0);
    bus(1'b1, 32'h4, 32'hff);
    rchk("sync fields", 32'h4, 32'h3f);
    bus(1'b1, 32'h4, 32'h0);
  endtask
  task automatic t_cmp;
    wcmp(1, 0, 12'h123);
    rchk("cmp low", 32'h40, 32'h23);
    rchk("cmp high", 32'h44, 32'h01);
    rchk("other module", 32'h24, 32'h0);
    hold <= 12'h123;
    bus(1'b1, 32'h8, 32'h04);
    bus(1'b1, 32'h0, 32'h3f);
    repeat (4) @(posedge clk);
    chk("pin enable", 32'h3f, 32'(oe));
    chk("1A high", 32'h1, 32'(pout[2]));
    bus(1'b1, 32'h8, 32'h00);
    repeat (3) @(posedge clk);
    chk("1A low", 32'h0, 32'(pout[2]));
    chk("1B idle low", 32'h1, 32'(pout[3]));
    bus(1'b1, 32'h8, 32'h0c);
    repeat (3) @(posedge clk);
    chk("1B idle high", 32'h0, 32'(pout[3]));
  endtask
  task automatic t_lock;
    bus(1'b1, 32'h8, 32'h24);
    bus(1'b1, 32'h0, 32'h00);
    wcmp(1, 1, 12'h123);
    repeat (4) @(posedge clk);
    chk("locked oe", 32'h3f, 32'(oe));
    chk("locked wave", 32'h1, 32'(pout[2]));
    bus(1'b1, 32'h8, 32'h04);
    repeat (4) @(posedge clk);
    chk("released oe", 32'h0, 32'(oe));
    chk("released wave", 32'h0, 32'(pout[2]));
  endtask
  task automatic t_irq;
    hold <= 12'h7ff;
    bus(1'b1, 32'h10, 32'h0);
    bus(1'b1, 32'hc, 32'hf);
    rchk("status clear", 32'hc, 32'h0);
    fevt <= 3'b100;
    @(posedge clk);
    fevt <= 3'b000;
    repeat (2) @(posedge clk);
    rchk("fault flag", 32'hc, 32'h8);
    chk("masked irq", 32'h0, 32'(irq));
    bus(1'b1, 32'h10, 32'h8);
    repeat (3) @(posedge clk);
    chk("fault irq", 32'h3, {30'h0, irq, irq_f});
    bus(1'b1, 32'hc, 32'h8);
    repeat (3) @(posedge clk);
    chk("fault cleared", 32'h0, 32'(irq_f));
    fevt <= 3'b010;
    @(posedge clk);
    fevt <= 3'b000;
    repeat (3) @(posedge clk);
    chk("other fault masked", 32'h0, 32'(irq_f));
    bus(1'b1, 32'h10, 32'h1);
    wcmp(2, 3, 12'h456);
    hold <= 12'h456;
    repeat (5) @(posedge clk);
    chk("end irq", 32'h1, 32'(irq_e));
    rchk("end flag", 32'hc, 32'h5);
    bus(1'b1, 32'h10, 32'h0);
    repeat (3) @(posedge clk);
    chk("end gated", 32'h0, 32'(irq_e));
  endtask
  task automatic pulses;
    n = 0;
    run <= 1'b1;
    repeat (32) begin
      @(posedge clk);
      #1;
      if (sync[0] === 1'b1) begin
        n++;
        seen = eng[0].count;
      end
    end
    @(posedge clk);
    run <= 1'b0;
  endtask
  task automatic t_sync;
    hold <= 12'h000;
    for (int f = 0; f < 4; f++) wcmp(0, f, vals[f]);
    for (int md = 0; md < 2; md++) begin
      bus(1'b1, 32'h8, 32'(md * 16 + 4));
      for (int c = 0; c < 4; c++) begin
        bus(1'b1, 32'h4, 32'(c));
        pulses();
        chk("sync count", md ? 32'(c == 1) : 32'h1, 32'(n));
        if (md == 0) chk("sync place", 32'(vals[c] + 1), 32'(seen));
      end
    end
    up <= 1'b0;
    bus(1'b1, 32'h4, 32'h0);
    pulses();
    chk("sync down", 32'h1, 32'(n));
    chk("sync down place", 32'(vals[1] - 1), 32'(seen));
    bus(1'b1, 32'h8, 32'h04);
    bus(1'b1, 32'h4, 32'h1);
    fa <= 3'b001;
    @(posedge clk);
    fa <= 3'b000;
    #1;
    chk("sync on fault", 32'h1, 32'(sync[0]));
    @(posedge clk);
    #1;
    chk("sync fault end", 32'h0, 32'(sync[0]));
  endtask

  // ---------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fevt = 3'b000;
    fa = 3'b000;
    run = 1'b0;
    up = 1'b1;
    hold = 12'h7ff;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_cmp();
    t_lock();
    t_irq();
    t_sync();
    results();
  end
  initial begin
    #400000;
    failures++;
    results();
  end
endmodule
